// >>> common/sptc_pkg.sv
// Package with register map, field layout and encodings of the split timer.
package sptc_pkg;
    // Register offsets.
    localparam logic [7:0] ADDR_CLOCK_SOURCE_FIELD = 8'h00;
    localparam logic [7:0] ADDR_CMPEN = 8'h01;
    localparam logic [7:0] ADDR_CMPVAL = 8'h02;
    localparam logic [7:0] ADDR_WIDTH_MODE_FIELD = 8'h04;
    localparam logic [7:0] ADDR_UNFLVL = 8'h06;
    localparam logic [7:0] ADDR_CMPLVL = 8'h07;
    localparam logic [7:0] ADDR_CMD = 8'h08;
    // Period, compare, count and flag registers of my own choosing.
    localparam logic [7:0] ADDR_FLAGS = 8'h0c;
    localparam logic [7:0] ADDR_LOW_COUNTER_VALUE = 8'h20;
    localparam logic [7:0] ADDR_HIGH_COUNTER_VALUE = 8'h21;
    localparam logic [7:0] ADDR_HPER = 8'h26;
    localparam logic [7:0] ADDR_LPER = 8'h27;
    localparam logic [7:0] ADDR_LCMP0 = 8'h28;
    localparam logic [7:0] ADDR_HCMP0 = 8'h2c;
    // Reset values.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_NIB = 4'h0;
    localparam logic [1:0] RST_TWO = 2'h0;
    // Clock select codes.
    localparam logic [3:0] CLK_OFF = 4'h0;
    localparam int PRESC_W = 10;
    // Commands and targets.
    localparam logic [1:0] CMD_NONE = 2'h0;
    localparam logic [1:0] CMD_RESTART = 2'h2;
    localparam logic [1:0] CMD_RESET = 2'h3;
    localparam logic [1:0] TGT_LOW = 2'h1;
    localparam logic [1:0] TGT_HIGH = 2'h2;
    localparam logic [1:0] TGT_BOTH = 2'h3;
    // Byte mode codes.
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_UPPER_ZERO = 2'h1;
    localparam logic [1:0] MODE_DUAL = 2'h2;
    // Width of a level field and number of channels per byte counter.
    localparam int LVL_W = 2;
    localparam int NCH = 4;

    // Register bus request carried as one struct.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sptc_bus_t;

    // Command written to the command register.
    typedef struct packed {
        logic [1:0] cmd;
        logic [1:0] target;
    } sptc_cmd_t;
endpackage

// >>> hw/sptc_top.sv
// Split dual eight-bit down timer: control registers, commands and counters.
`timescale 1ns/10ps

// Summary of operation
// - Commands act in the write cycle itself.
// - Code 10 restarts targeted counter periods.
// - Restart zeroes count and outputs.
// - Code 11 returns all registers to reset.
// - Reset command ignored unless clock stopped.
// - Codes 00/01 do nothing; command reads zero.
// - Clock select picks prescaler tap or event.
// - One clock selection drives both counters.
// - Enable bits gate waveform onto pin override.
// - Value bits give direct output access when stopped.
// - Byte mode selects normal or dual counters.
// - Upper-zero mode clears high byte each tick.
// - High underflow level field requests interrupt.
// - Low underflow level field requests interrupt.
// - Compare level fields request per-channel interrupts.
// - Reserved bits read zero, ignore writes.
// - Target 01 low, 10 high, 11 both.
// - Underflow flag sets at bottom, clears on ack.
// - Count down, reload from period after bottom.
// - Output set on match, cleared at bottom.
module sptc_top #(
    parameter int PW = sptc_pkg::PRESC_W
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire sptc_pkg::sptc_bus_t i_bus,
    input wire logic [7:0] i_evt,
    input wire logic [5:0] i_irq_ack,
    output logic [7:0] o_rdata,
    output logic [7:0] o_ovr_en,
    output logic [7:0] o_wave,
    output logic [1:0] o_irq_lvl_lunf,
    output logic [1:0] o_irq_lvl_hunf,
    output logic [7:0] o_irq_lvl_cmp
);
    // Control registers.
    logic [3:0] clk_sel_q;
    logic [7:0] cmp_en_q;
    logic [1:0] byte_mode_q;
    logic [3:0] unf_lvl_q;
    logic [7:0] cmp_lvl_q;
    // Counter state, period and compare values.
    logic [7:0] low_counter_value_q;
    logic [7:0] high_counter_value_q;
    logic [7:0] lper_q;
    logic [7:0] hper_q;
    logic [7:0] lcmp_q [sptc_pkg::NCH];
    logic [7:0] hcmp_q [sptc_pkg::NCH];
    // Waveform outputs: high channels in 7:4, low in 3:0.
    logic [7:0] wave_q;
    // Flags: compare 7:4, high underflow 1, low underflow 0.
    logic [7:0] flags_q;
    // Prescaler and event synchronisers.
    logic [PW-1:0] presc_q;
    logic [7:0] evt_s1_q;
    logic [7:0] evt_s2_q;
    logic [7:0] evt_s3_q;
    logic tick;
    // Decoded bus accesses.
    sptc_pkg::sptc_cmd_t cmd;
    logic cmd_wr;
    logic hard_rst;
    logic restart_l;
    logic restart_h;
    logic running;
    logic l_bottom;
    logic h_bottom;

    assign running = (clk_sel_q != sptc_pkg::CLK_OFF);
    assign cmd = i_bus.wdata[3:0];
    // Command acts in the cycle of the write itself.
    assign cmd_wr = i_bus.wr && (i_bus.addr == sptc_pkg::ADDR_CMD);
    // Reset only while stopped; codes 00 and 01 fall through.
    assign hard_rst = cmd_wr && (cmd.cmd == sptc_pkg::CMD_RESET) && !running;
    // Restart targets decoded; target 00 selects nothing.
    assign restart_l = cmd_wr && (cmd.cmd == sptc_pkg::CMD_RESTART) &&
        (cmd.target == sptc_pkg::TGT_LOW || cmd.target == sptc_pkg::TGT_BOTH);
    assign restart_h = cmd_wr && (cmd.cmd == sptc_pkg::CMD_RESTART) &&
        (cmd.target == sptc_pkg::TGT_HIGH ||
         cmd.target == sptc_pkg::TGT_BOTH);
    assign l_bottom = (low_counter_value_q == sptc_pkg::RST_BYTE);
    assign h_bottom = (high_counter_value_q == sptc_pkg::RST_BYTE);

    // Peripheral clock prescaler, held at zero while the clock select is off.
    always_ff @(posedge i_clk) begin
        if (i_rst || hard_rst || !running) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_q + 1'b1;
        end
    end

    // Event inputs pass two flops; the third gives the edge.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            evt_s1_q <= sptc_pkg::RST_BYTE;
            evt_s2_q <= sptc_pkg::RST_BYTE;
            evt_s3_q <= sptc_pkg::RST_BYTE;
        end else begin
            evt_s1_q <= i_evt;
            evt_s2_q <= evt_s1_q;
            evt_s3_q <= evt_s2_q;
        end
    end

    // One shared count tick from the selected source.
    always_comb begin
        tick = 1'b0;
        if (clk_sel_q[3]) begin
            tick = evt_s2_q[clk_sel_q[2:0]] && !evt_s3_q[clk_sel_q[2:0]];
        end else begin
            unique case (clk_sel_q[2:0])
                3'h0: tick = 1'b0;
                3'h1: tick = 1'b1;
                3'h2: tick = &presc_q[0:0];
                3'h3: tick = &presc_q[1:0];
                3'h4: tick = &presc_q[2:0];
                3'h5: tick = &presc_q[5:0];
                3'h6: tick = &presc_q[7:0];
                3'h7: tick = &presc_q[PW-1:0];
            endcase
        end
    end

    // Control registers; reserved bits are never stored.
    always_ff @(posedge i_clk) begin
        if (i_rst || hard_rst) begin
            clk_sel_q <= sptc_pkg::RST_NIB;
            cmp_en_q <= sptc_pkg::RST_BYTE;
            byte_mode_q <= sptc_pkg::RST_TWO;
            unf_lvl_q <= sptc_pkg::RST_NIB;
            cmp_lvl_q <= sptc_pkg::RST_BYTE;
        end else if (i_bus.wr) begin
            unique case (i_bus.addr)
                sptc_pkg::ADDR_CLOCK_SOURCE_FIELD: clk_sel_q <= i_bus.wdata[3:0];
                sptc_pkg::ADDR_CMPEN: cmp_en_q <= i_bus.wdata;
                sptc_pkg::ADDR_WIDTH_MODE_FIELD: byte_mode_q <= i_bus.wdata[1:0];
                sptc_pkg::ADDR_UNFLVL: unf_lvl_q <= i_bus.wdata[3:0];
                sptc_pkg::ADDR_CMPLVL: cmp_lvl_q <= i_bus.wdata;
                default: ;
            endcase
        end
    end

    // Period and compare registers.
    always_ff @(posedge i_clk) begin
        if (i_rst || hard_rst) begin
            lper_q <= sptc_pkg::RST_BYTE;
            hper_q <= sptc_pkg::RST_BYTE;
            for (int i = 0; i < sptc_pkg::NCH; i++) begin
                lcmp_q[i] <= sptc_pkg::RST_BYTE;
                hcmp_q[i] <= sptc_pkg::RST_BYTE;
            end
        end else if (i_bus.wr) begin
            if (i_bus.addr == sptc_pkg::ADDR_LPER) begin
                lper_q <= i_bus.wdata;
            end
            if (i_bus.addr == sptc_pkg::ADDR_HPER) begin
                hper_q <= i_bus.wdata;
            end
            for (int i = 0; i < sptc_pkg::NCH; i++) begin
                if (i_bus.addr == sptc_pkg::ADDR_LCMP0 + 8'(i)) begin
                    lcmp_q[i] <= i_bus.wdata;
                end
                if (i_bus.addr == sptc_pkg::ADDR_HCMP0 + 8'(i)) begin
                    hcmp_q[i] <= i_bus.wdata;
                end
            end
        end
    end

    // Low counter: write wins, then restart, then count and reload.
    always_ff @(posedge i_clk) begin
        if (i_rst || hard_rst) begin
            low_counter_value_q <= sptc_pkg::RST_BYTE;
        end else if (i_bus.wr && i_bus.addr == sptc_pkg::ADDR_LOW_COUNTER_VALUE) begin
            low_counter_value_q <= i_bus.wdata;
        end else if (restart_l) begin
            low_counter_value_q <= sptc_pkg::RST_BYTE;
        end else if (tick) begin
            low_counter_value_q <= l_bottom ? lper_q : low_counter_value_q - 8'h01;
        end
    end

    // High counter; upper-zero mode clears it on every tick.
    always_ff @(posedge i_clk) begin
        if (i_rst || hard_rst) begin
            high_counter_value_q <= sptc_pkg::RST_BYTE;
        end else if (i_bus.wr && i_bus.addr == sptc_pkg::ADDR_HIGH_COUNTER_VALUE) begin
            high_counter_value_q <= i_bus.wdata;
        end else if (restart_h) begin
            high_counter_value_q <= sptc_pkg::RST_BYTE;
        end else if (tick && byte_mode_q == sptc_pkg::MODE_UPPER_ZERO) begin
            high_counter_value_q <= sptc_pkg::RST_BYTE;
        end else if (tick && byte_mode_q == sptc_pkg::MODE_DUAL) begin
            high_counter_value_q <= h_bottom ? hper_q : high_counter_value_q - 8'h01;
        end
    end

    // Waveform generators, one per channel of each byte counter.
    for (genvar c = 0; c < sptc_pkg::NCH; c++) begin : g_wave
        always_ff @(posedge i_clk) begin
            if (i_rst || hard_rst) begin
                wave_q[c] <= 1'b0;
                wave_q[c+sptc_pkg::NCH] <= 1'b0;
            end else if (!running && i_bus.wr &&
                         i_bus.addr == sptc_pkg::ADDR_CMPVAL) begin
                // Direct access only while stopped.
                wave_q[c] <= i_bus.wdata[c];
                wave_q[c+sptc_pkg::NCH] <= i_bus.wdata[c+sptc_pkg::NCH];
            end else begin
                if (restart_l) begin
                    wave_q[c] <= 1'b0;
                end else if (tick && l_bottom) begin
                    wave_q[c] <= 1'b0;
                end else if (tick && low_counter_value_q == lcmp_q[c]) begin
                    wave_q[c] <= 1'b1;
                end
                if (restart_h) begin
                    wave_q[c+sptc_pkg::NCH] <= 1'b0;
                end else if (tick && h_bottom) begin
                    wave_q[c+sptc_pkg::NCH] <= 1'b0;
                end else if (tick && high_counter_value_q == hcmp_q[c]) begin
                    wave_q[c+sptc_pkg::NCH] <= 1'b1;
                end
            end
        end
    end

    // Flags: hardware set wins over a write-one or vector clear.
    always_ff @(posedge i_clk) begin
        if (i_rst || hard_rst) begin
            flags_q <= sptc_pkg::RST_BYTE;
        end else begin
            for (int b = 0; b < 8; b++) begin
                if (b == 2 || b == 3) begin
                    flags_q[b] <= 1'b0;
                end else if ((b == 0 && tick && l_bottom) ||
                             (b == 1 && tick && h_bottom &&
                              byte_mode_q == sptc_pkg::MODE_DUAL) ||
                             (b > 3 && tick && low_counter_value_q == lcmp_q[b-4])) begin
                    flags_q[b] <= 1'b1;
                end else if ((i_bus.wr && i_bus.addr == sptc_pkg::ADDR_FLAGS
                              && i_bus.wdata[b]) ||
                             i_irq_ack[(b > 3) ? b - 2 : b & 1]) begin
                    flags_q[b] <= 1'b0;
                end
            end
        end
    end

    // Interrupt requests carry their level; zero level is none.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_irq_lvl_lunf <= sptc_pkg::RST_TWO;
            o_irq_lvl_hunf <= sptc_pkg::RST_TWO;
            o_irq_lvl_cmp <= sptc_pkg::RST_BYTE;
        end else begin
            o_irq_lvl_lunf <= flags_q[0] ? unf_lvl_q[1:0] : 2'h0;
            o_irq_lvl_hunf <= flags_q[1] ? unf_lvl_q[3:2] : 2'h0;
            for (int i = 0; i < sptc_pkg::NCH; i++) begin
                o_irq_lvl_cmp[2*i+:2] <= flags_q[4+i] ?
                    cmp_lvl_q[2*i+:2] : 2'h0;
            end
        end
    end

    // Pin override and waveform outputs.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_ovr_en <= sptc_pkg::RST_BYTE;
            o_wave <= sptc_pkg::RST_BYTE;
        end else begin
            o_ovr_en <= cmp_en_q;
            o_wave <= wave_q & cmp_en_q;
        end
    end

    // Read data one cycle after the strobe; command and reserved read 0.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata <= sptc_pkg::RST_BYTE;
        end else if (i_bus.rd) begin
            unique case (i_bus.addr)
                sptc_pkg::ADDR_CLOCK_SOURCE_FIELD: o_rdata <= {4'h0, clk_sel_q};
                sptc_pkg::ADDR_CMPEN: o_rdata <= cmp_en_q;
                sptc_pkg::ADDR_CMPVAL: o_rdata <= wave_q;
                sptc_pkg::ADDR_WIDTH_MODE_FIELD: o_rdata <= {6'h00, byte_mode_q};
                sptc_pkg::ADDR_UNFLVL: o_rdata <= {4'h0, unf_lvl_q};
                sptc_pkg::ADDR_CMPLVL: o_rdata <= cmp_lvl_q;
                sptc_pkg::ADDR_FLAGS: o_rdata <= flags_q;
                sptc_pkg::ADDR_LOW_COUNTER_VALUE: o_rdata <= low_counter_value_q;
                sptc_pkg::ADDR_HIGH_COUNTER_VALUE: o_rdata <= high_counter_value_q;
                sptc_pkg::ADDR_LPER: o_rdata <= lper_q;
                sptc_pkg::ADDR_HPER: o_rdata <= hper_q;
                default: o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // Checks on command, counter and output behaviour.
    AST_RESET_IGNORED: assert property (@(posedge i_clk) disable iff (i_rst)
        cmd_wr && cmd.cmd == sptc_pkg::CMD_RESET && running
        |=> clk_sel_q == $past(clk_sel_q))
        else $error("reset command acted while running");
    AST_RESET_CLEARS: assert property (@(posedge i_clk) disable iff (i_rst)
        hard_rst |=> clk_sel_q == 4'h0 && cmp_en_q == 8'h00)
        else $error("reset command left registers set");
    AST_RESTART_LOW: assert property (@(posedge i_clk) disable iff (i_rst)
        restart_l && !(i_bus.addr == sptc_pkg::ADDR_LOW_COUNTER_VALUE)
        |=> low_counter_value_q == 8'h00 && wave_q[3:0] == 4'h0)
        else $error("restart did not clear low counter");
    AST_RELOAD: assert property (@(posedge i_clk) disable iff (i_rst)
        tick && l_bottom && !i_bus.wr && !cmd_wr |=> low_counter_value_q == $past(lper_q))
        else $error("low counter did not reload");
    AST_UPPER_ZERO: assert property (@(posedge i_clk) disable iff (i_rst)
        tick && byte_mode_q == sptc_pkg::MODE_UPPER_ZERO && !i_bus.wr
        |=> high_counter_value_q == 8'h00)
        else $error("upper byte not cleared");
    AST_VALUE_LOCKED: assert property (@(posedge i_clk) disable iff (i_rst)
        running && !tick && !cmd_wr |=> wave_q == $past(wave_q))
        else $error("waveform changed without tick");
    AST_CMD_READ_ZERO: assert property (@(posedge i_clk) disable iff (i_rst)
        i_bus.rd && i_bus.addr == sptc_pkg::ADDR_CMD |=> o_rdata == 8'h00)
        else $error("command field read nonzero");
    AST_IRQ_LEVEL: assert property (@(posedge i_clk) disable iff (i_rst)
        flags_q[0] |=> o_irq_lvl_lunf == $past(unf_lvl_q[1:0]))
        else $error("low underflow request level wrong");
    AST_OVERRIDE: assert property (@(posedge i_clk) disable iff (i_rst)
        ##1 (o_wave & ~o_ovr_en) == 8'h00)
        else $error("wave on disabled channel");
    COV_RESTART: cover property (@(posedge i_clk) restart_l && restart_h);
    COV_RESET: cover property (@(posedge i_clk) hard_rst);
    COV_UNDERFLOW: cover property (@(posedge i_clk) tick && l_bottom);
    COV_EVENT: cover property (@(posedge i_clk) tick && clk_sel_q[3]);
endmodule

// >>> tb/sptc_top_tb_top.sv
// Self-checking testbench for the split timer control and command block.
`timescale 1ns/10ps
module sptc_top_tb_top;
    logic i_clk; // Bench clock.
    logic i_rst; // Synchronous reset, active high.
    sptc_pkg::sptc_bus_t i_bus; // Register bus request.
    logic [7:0] i_evt; // Event channel levels.
    logic [5:0] i_irq_ack; // Vector executed pulses.
    logic [7:0] o_rdata;
    logic [7:0] o_ovr_en;
    logic [7:0] o_wave;
    logic [1:0] o_irq_lvl_lunf;
    logic [1:0] o_irq_lvl_hunf;
    logic [7:0] o_irq_lvl_cmp;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0; // Cycle count for the hang guard.
    logic [7:0] v; // Value of the last register read.
    // Every control register, walked for reset values.
    localparam logic [7:0] REGS [0:6] = '{sptc_pkg::ADDR_CLOCK_SOURCE_FIELD,
        sptc_pkg::ADDR_CMPEN, sptc_pkg::ADDR_CMPVAL, sptc_pkg::ADDR_WIDTH_MODE_FIELD,
        sptc_pkg::ADDR_UNFLVL, sptc_pkg::ADDR_CMPLVL, sptc_pkg::ADDR_CMD};

    sptc_top u_dut (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_bus(i_bus),
        .i_evt(i_evt),
        .i_irq_ack(i_irq_ack),
        .o_rdata(o_rdata),
        .o_ovr_en(o_ovr_en),
        .o_wave(o_wave),
        .o_irq_lvl_lunf(o_irq_lvl_lunf),
        .o_irq_lvl_hunf(o_irq_lvl_hunf),
        .o_irq_lvl_cmp(o_irq_lvl_cmp)
    );

    // Free running 100 MHz clock.
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // Hang guard: the whole run needs well under this many cycles.
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            test_done();
        end
    end

    // Prints the verdict and ends the run.
    task automatic test_done();
        if (mismatches == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Compares one value and reports a difference at once.
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One write cycle; the strobe drops at the edge that takes it.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        i_bus <= '0;
    endtask

    // One read cycle; data are taken in the following cycle only.
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        i_bus <= '0;
        #1 v = o_rdata;
    endtask

    // Reads a register and compares it.
    task automatic rdchk(input string what, input logic [7:0] a,
                         input logic [7:0] exp);
        rd(a);
        check(what, v, exp);
    endtask

    // Lets registered outputs catch up, then samples 1 ns after the edge.
    task automatic settle(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // One rising edge on an event channel, long enough for the synchroniser.
    task automatic pulse_evt(input int ch);
        @(posedge i_clk);
        i_evt[ch] <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_evt[ch] <= 1'b0;
        repeat (3) @(posedge i_clk);
    endtask

    // One cycle pulse on the vector executed inputs.
    task automatic ack(input logic [5:0] m);
        @(posedge i_clk);
        i_irq_ack <= m;
        @(posedge i_clk);
        i_irq_ack <= '0;
    endtask

    // The control registers come up zero; an unmapped place reads zero.
    task automatic t_reset_values();
        for (int i = 0; i < 7; i++) begin
            rdchk("reset value", REGS[i], 8'h00);
        end
        rdchk("unmapped", 8'h03, 8'h00);
    endtask

    // Writable fields keep their bits, reserved bits stay zero.
    task automatic t_masks();
        wr(sptc_pkg::ADDR_CLOCK_SOURCE_FIELD, 8'hf7);
        rdchk("clock select", sptc_pkg::ADDR_CLOCK_SOURCE_FIELD, 8'h07);
        wr(sptc_pkg::ADDR_CLOCK_SOURCE_FIELD, 8'h00);
        wr(sptc_pkg::ADDR_CMPEN, 8'h5a);
        rdchk("enables", sptc_pkg::ADDR_CMPEN, 8'h5a);
        settle(2);
        check("override", o_ovr_en, 8'h5a);
        wr(sptc_pkg::ADDR_WIDTH_MODE_FIELD, 8'hfe);
        rdchk("byte mode", sptc_pkg::ADDR_WIDTH_MODE_FIELD, 8'h02);
        wr(sptc_pkg::ADDR_UNFLVL, 8'hf6);
        rdchk("unf levels", sptc_pkg::ADDR_UNFLVL, 8'h06);
        wr(sptc_pkg::ADDR_CMPLVL, 8'ha5);
        rdchk("cmp levels", sptc_pkg::ADDR_CMPLVL, 8'ha5);
        // Reserved code 01 with a low target: no action, reads back zero.
        wr(sptc_pkg::ADDR_CMD, 8'h05);
        rd(sptc_pkg::ADDR_CMD);
        check("command bits", v, 8'h00);
    endtask

    // The reset command is refused while running and obeyed when stopped.
    task automatic t_reset_cmd();
        wr(sptc_pkg::ADDR_LOW_COUNTER_VALUE, 8'h33);
        wr(sptc_pkg::ADDR_CLOCK_SOURCE_FIELD, 8'h08);
        wr(sptc_pkg::ADDR_CMD, 8'h0f);
        rdchk("refused reset", sptc_pkg::ADDR_CMPEN, 8'h5a);
        wr(sptc_pkg::ADDR_CLOCK_SOURCE_FIELD, 8'h00);
        wr(sptc_pkg::ADDR_CMD, 8'h0f);
        for (int i = 0; i < 7; i++) begin
            rdchk("after reset", REGS[i], 8'h00);
        end
        rdchk("count after reset", sptc_pkg::ADDR_LOW_COUNTER_VALUE, 8'h00);
    endtask

    // Forced values, no-action codes and restart aimed at each target.
    task automatic t_commands();
        logic [7:0] idle [0:1] = '{8'h03, 8'h07};
        wr(sptc_pkg::ADDR_CMPEN, 8'hff);
        wr(sptc_pkg::ADDR_CMPVAL, 8'h3c);
        settle(2);
        check("forced wave", o_wave, 8'h3c);
        rdchk("value reg", sptc_pkg::ADDR_CMPVAL, 8'h3c);
        wr(sptc_pkg::ADDR_LOW_COUNTER_VALUE, 8'h40);
        wr(sptc_pkg::ADDR_HIGH_COUNTER_VALUE, 8'h40);
        for (int i = 0; i < 2; i++) begin
            wr(sptc_pkg::ADDR_CMD, idle[i]);
            settle(2);
            check("no action", o_wave, 8'h3c);
        end
        wr(sptc_pkg::ADDR_CMD, 8'h09);
        settle(2);
        check("restart low", o_wave, 8'h30);
        rdchk("low count", sptc_pkg::ADDR_LOW_COUNTER_VALUE, 8'h00);
        rdchk("high kept", sptc_pkg::ADDR_HIGH_COUNTER_VALUE, 8'h40);
        wr(sptc_pkg::ADDR_CMD, 8'h0a);
        settle(2);
        check("restart high", o_wave, 8'h00);
        rdchk("high count", sptc_pkg::ADDR_HIGH_COUNTER_VALUE, 8'h00);
        wr(sptc_pkg::ADDR_CMPVAL, 8'hff);
        wr(sptc_pkg::ADDR_CMD, 8'h0b);
        settle(2);
        check("restart both", o_wave, 8'h00);
        // Event clock with a quiet channel: running but never ticking.
        wr(sptc_pkg::ADDR_CLOCK_SOURCE_FIELD, 8'h08);
        wr(sptc_pkg::ADDR_CMPVAL, 8'hff);
        settle(2);
        check("value while running", o_wave, 8'h00);
        rdchk("value reg running", sptc_pkg::ADDR_CMPVAL, 8'h00);
        wr(sptc_pkg::ADDR_CLOCK_SOURCE_FIELD, 8'h00);
    endtask

    // Event channels clock both counters; upper-zero mode clears the high.
    task automatic t_event();
        wr(sptc_pkg::ADDR_WIDTH_MODE_FIELD, 8'h02);
        wr(sptc_pkg::ADDR_LPER, 8'hff);
        wr(sptc_pkg::ADDR_HPER, 8'hff);
        wr(sptc_pkg::ADDR_LOW_COUNTER_VALUE, 8'h0a);
        wr(sptc_pkg::ADDR_HIGH_COUNTER_VALUE, 8'h14);
        wr(sptc_pkg::ADDR_CLOCK_SOURCE_FIELD, 8'h08);
        repeat (3) pulse_evt(1);
        repeat (3) pulse_evt(0);
        rdchk("low by event", sptc_pkg::ADDR_LOW_COUNTER_VALUE, 8'h07);
        rdchk("high by event", sptc_pkg::ADDR_HIGH_COUNTER_VALUE, 8'h11);
        wr(sptc_pkg::ADDR_CLOCK_SOURCE_FIELD, 8'h09);
        repeat (2) pulse_evt(1);
        rdchk("channel one", sptc_pkg::ADDR_LOW_COUNTER_VALUE, 8'h05);
        wr(sptc_pkg::ADDR_WIDTH_MODE_FIELD, 8'h01);
        wr(sptc_pkg::ADDR_HIGH_COUNTER_VALUE, 8'h05);
        pulse_evt(1);
        rdchk("upper zeroed", sptc_pkg::ADDR_HIGH_COUNTER_VALUE, 8'h00);
        wr(sptc_pkg::ADDR_CLOCK_SOURCE_FIELD, 8'h00);
    endtask

    // Each prescaler tap gives about eight ticks in eight of its periods.
    task automatic t_presc();
        int dv;
        wr(sptc_pkg::ADDR_WIDTH_MODE_FIELD, 8'h02);
        for (int k = 1; k < 8; k++) begin
            dv = (k < 5) ? (1 << (k - 1)) : (1 << (2 * k - 4));
            wr(sptc_pkg::ADDR_LOW_COUNTER_VALUE, 8'hc8);
            wr(sptc_pkg::ADDR_CLOCK_SOURCE_FIELD, 8'(k));
            repeat (8 * dv) @(posedge i_clk);
            wr(sptc_pkg::ADDR_CLOCK_SOURCE_FIELD, 8'h00);
            rd(sptc_pkg::ADDR_LOW_COUNTER_VALUE);
            check("prescaled", {7'h00, v <= 8'hc1 && v >= 8'hbd}, 8'h01);
        end
    endtask

    // Underflow and compare requests follow flags, levels and clears.
    task automatic t_irq();
        wr(sptc_pkg::ADDR_LPER, 8'h03);
        wr(sptc_pkg::ADDR_HPER, 8'h03);
        wr(sptc_pkg::ADDR_LOW_COUNTER_VALUE, 8'h03);
        wr(sptc_pkg::ADDR_HIGH_COUNTER_VALUE, 8'h03);
        for (int c = 0; c < 4; c++) begin
            wr(sptc_pkg::ADDR_LCMP0 + 8'(c), 8'h02);
        end
        wr(sptc_pkg::ADDR_UNFLVL, 8'h09);
        wr(sptc_pkg::ADDR_CMPLVL, 8'he4);
        wr(sptc_pkg::ADDR_CLOCK_SOURCE_FIELD, 8'h01);
        settle(12);
        wr(sptc_pkg::ADDR_CLOCK_SOURCE_FIELD, 8'h00);
        settle(2);
        check("low unf level", {6'h00, o_irq_lvl_lunf}, 8'h01);
        check("high unf level", {6'h00, o_irq_lvl_hunf}, 8'h02);
        check("cmp levels", o_irq_lvl_cmp, 8'he4);
        rdchk("flags", sptc_pkg::ADDR_FLAGS, 8'hf3);
        wr(sptc_pkg::ADDR_UNFLVL, 8'h00);
        settle(2);
        check("low off", {6'h00, o_irq_lvl_lunf}, 8'h00);
        check("high off", {6'h00, o_irq_lvl_hunf}, 8'h00);
        wr(sptc_pkg::ADDR_UNFLVL, 8'h05);
        ack(6'h01);
        settle(2);
        check("low acked", {6'h00, o_irq_lvl_lunf}, 8'h00);
        check("high held", {6'h00, o_irq_lvl_hunf}, 8'h01);
        wr(sptc_pkg::ADDR_FLAGS, 8'h02);
        settle(2);
        check("high cleared", {6'h00, o_irq_lvl_hunf}, 8'h00);
        ack(6'h3c);
        settle(2);
        check("cmp acked", o_irq_lvl_cmp, 8'h00);
    endtask

    // Main sequence: reset for four cycles, then every scenario in turn.
    initial begin
        i_rst = 1'b1;
        i_bus = '0;
        i_evt = '0;
        i_irq_ack = '0;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset_values();
        t_masks();
        t_reset_cmd();
        t_commands();
        t_event();
        t_presc();
        t_irq();
        test_done();
    end
endmodule
